// File: tcco_pkg.sv
/*
 * Constants, register layouts and mode codes for the timer capture/compare
 * and output control block. Assumes an AXI4-Lite master with 32-bit data.
 */
package tcco_pkg;
   // Bus geometry: register index times four is the byte address
   localparam int          ADDR_W      = 18;
   localparam int          IDX_W       = 16;
   localparam logic [15:0] IDX_CRA     = 16'hffb0;  // compare_reg_a
   localparam logic [15:0] IDX_CRB     = 16'hffb1;  // compare_reg_b
   localparam logic [15:0] IDX_CNT     = 16'hffb2;  // timer_count, read only
   localparam logic [15:0] IDX_TMC     = 16'hffba;  // run mode register
   localparam logic [15:0] IDX_PRM     = 16'hffbb;  // prescaler_mode_reg
   localparam logic [15:0] IDX_CCC     = 16'hffbc;  // capture_compare_control
   localparam logic [15:0] IDX_TOC     = 16'hffbd;  // timer_output_control
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // Values after reset
   localparam logic [7:0]  CCC_RST = 8'h00;
   localparam logic [7:0]  TOC_RST = 8'h00;
   localparam logic [7:0]  TMC_RST = 8'h00;
   localparam logic [7:0]  PRM_RST = 8'h00;
   localparam logic [15:0] CR_RST  = 16'h0000;

   // Edge selection and count clock codes
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [1:0] CLK_FULL  = 2'h0;
   localparam logic [1:0] CLK_DIV4  = 2'h1;
   localparam logic [1:0] CLK_PIN   = 2'h3;
   localparam logic [1:0] DIV_LAST  = 2'h3;  // Divide-by-four prescaler wraps here

   typedef enum logic [1:0] {RUN_STOP, RUN_FREE, RUN_EDGE_CLR, RUN_MATCH_CLR} tcco_run_t;

   typedef struct packed {
      logic [4:0] rsv;
      logic       reg_b_capture_sel;
      logic       reg_a_trigger_sel;
      logic       reg_a_capture_sel;
   } tcco_ccc_t;

   typedef struct packed {
      logic rsv;
      logic oneshot_sw_trigger;
      logic oneshot_enable;
      logic invert_on_b_match;
      logic level_set_trigger;
      logic level_clear_trigger;
      logic invert_on_a_match;
      logic output_enable_bit;
   } tcco_toc_t;

   typedef struct packed {
      logic [3:0] rsv;
      logic       run_mode_hi;
      logic       run_mode_lo;
      logic       invert_on_edge;
      logic       overflow;
   } tcco_tmc_t;

   typedef struct packed {
      logic [1:0] edge_sel_b;
      logic       edge_sel_a_hi;
      logic       edge_sel_a_lo;
      logic [1:0] rsv;
      logic [1:0] clk_sel;
   } tcco_prm_t;
endpackage

// File: tcco_top.sv
/*
 * 16-bit timer with two capture/compare registers and output pin control,
 * reached over AXI4-Lite. Assumes pins are synchronous to aclk and that
 * software keeps to the write-ordering rules of the output control register.
 */
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tcco_top (
   // Clock and reset
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // AXI4-Lite write channels
   input  wire logic [tcco_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                       awvalid,
   output      logic                       awready,
   input  wire logic [31:0]                wdata,
   input  wire logic [3:0]                 wstrb,
   input  wire logic                       wvalid,
   output      logic                       wready,
   output      logic [1:0]                 bresp,
   output      logic                       bvalid,
   input  wire logic                       bready,
   // AXI4-Lite read channels
   input  wire logic [tcco_pkg::ADDR_W-1:0] araddr,
   input  wire logic                       arvalid,
   output      logic                       arready,
   output      logic [31:0]                rdata,
   output      logic [1:0]                 rresp,
   output      logic                       rvalid,
   input  wire logic                       rready,
   // Timer pins and events
   input  wire logic                       input_pin_a,
   input  wire logic                       input_pin_b,
   output      logic                       timer_out_pin,
   output      logic                       match_irq_a,
   output      logic                       match_irq_b
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers and status
   tcco_pkg::tcco_ccc_t ccc_q;
   tcco_pkg::tcco_toc_t toc_q;
   tcco_pkg::tcco_tmc_t tmc_q;
   tcco_pkg::tcco_prm_t prm_q;
   logic [15:0]         cra_q, crb_q, cnt_q, cnt_d;
   logic [1:0]          div_q;
   logic                pa_q, pb_q, os_act_q, level_q, level_d, pin_q;
   logic                irq_a_q, irq_b_q;
   tcco_pkg::tcco_run_t run;
   logic                running, tick, a_rise, a_fall, b_rise, b_fall;
   logic                a_edge, b_edge, a_rev, cap_a_ev, cap_b_ev, rev_irq;
   logic                hit_a, hit_b, tog_ok, wrap;

   // AXI slave state
   logic                    aw_full_q, w_full_q, bvalid_q, rvalid_q;
   logic [tcco_pkg::IDX_W-1:0] aw_idx_q;
   logic [31:0]             wd_q, rdata_q;
   logic [3:0]              ws_q;
   logic [1:0]              bresp_q, rresp_q;
   logic                    wr_go, wr_hit;
   logic                    wr_ccc, wr_toc, wr_tmc, wr_prm, wr_cra, wr_crb;
   tcco_pkg::tcco_toc_t     wtoc;

   // Valid-edge decode of a 2-bit edge selection field
   function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
      case (sel)
         tcco_pkg::EDGE_FALL: edge_hit = f;
         tcco_pkg::EDGE_RISE: edge_hit = r;
         tcco_pkg::EDGE_BOTH: edge_hit = r | f;
         default:             edge_hit = 1'b0;  // Prohibited code selects nothing
      endcase
   endfunction

   // Opposite-phase edge; both-edge selection leaves no opposite edge
   function automatic logic rev_hit(input logic [1:0] sel, input logic r, input logic f);
      case (sel)
         tcco_pkg::EDGE_FALL: rev_hit = r;
         tcco_pkg::EDGE_RISE: rev_hit = f;
         default:             rev_hit = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   assign awready = !aw_full_q && !bvalid_q;
   assign wready  = !w_full_q && !bvalid_q;
   assign arready = !rvalid_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;
   assign wr_go   = aw_full_q && w_full_q && !bvalid_q;
   assign wtoc    = tcco_pkg::tcco_toc_t'(wd_q[7:0]);

   // Write decode; only the low byte lane carries the 8-bit registers
   always_comb begin
      wr_ccc = wr_go && ws_q[0] && (aw_idx_q == tcco_pkg::IDX_CCC);
      wr_toc = wr_go && ws_q[0] && (aw_idx_q == tcco_pkg::IDX_TOC);
      wr_tmc = wr_go && ws_q[0] && (aw_idx_q == tcco_pkg::IDX_TMC);
      wr_prm = wr_go && ws_q[0] && (aw_idx_q == tcco_pkg::IDX_PRM);
      wr_cra = wr_go && (aw_idx_q == tcco_pkg::IDX_CRA);
      wr_crb = wr_go && (aw_idx_q == tcco_pkg::IDX_CRB);
      wr_hit = (aw_idx_q == tcco_pkg::IDX_CCC) || (aw_idx_q == tcco_pkg::IDX_TOC) ||
               (aw_idx_q == tcco_pkg::IDX_TMC) || (aw_idx_q == tcco_pkg::IDX_PRM) ||
               (aw_idx_q == tcco_pkg::IDX_CRA) || (aw_idx_q == tcco_pkg::IDX_CRB) ||
               (aw_idx_q == tcco_pkg::IDX_CNT);
   end

   // Address and data are held separately so either may arrive first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= tcco_pkg::RESP_OKAY;
         aw_idx_q  <= '0;
         wd_q      <= '0;
         ws_q      <= '0;
      end else begin
         if (awvalid && awready) begin
            aw_full_q <= 1'b1;
            aw_idx_q  <= awaddr[tcco_pkg::ADDR_W-1:2];
         end
         if (wvalid && wready) begin
            w_full_q <= 1'b1;
            wd_q     <= wdata;
            ws_q     <= wstrb;
         end
         if (wr_go) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_hit ? tcco_pkg::RESP_OKAY : tcco_pkg::RESP_SLVERR;
         end else if (bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Read path; trigger bits are never stored, so they read as zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= tcco_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_q <= 1'b1;
         rresp_q  <= tcco_pkg::RESP_OKAY;
         case (araddr[tcco_pkg::ADDR_W-1:2])
            tcco_pkg::IDX_CCC: rdata_q <= {24'h000000, ccc_q};
            tcco_pkg::IDX_TOC: rdata_q <= {24'h000000, toc_q};
            tcco_pkg::IDX_TMC: rdata_q <= {24'h000000, tmc_q};
            tcco_pkg::IDX_PRM: rdata_q <= {24'h000000, prm_q};
            tcco_pkg::IDX_CRA: rdata_q <= {16'h0000, cra_q};
            tcco_pkg::IDX_CRB: rdata_q <= {16'h0000, crb_q};
            tcco_pkg::IDX_CNT: rdata_q <= {16'h0000, cnt_q};
            default: begin
               rdata_q <= '0;
               rresp_q <= tcco_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ccc_q <= tcco_pkg::CCC_RST;
         toc_q <= tcco_pkg::TOC_RST;
         prm_q <= tcco_pkg::PRM_RST;
      end else begin
         if (wr_ccc) ccc_q <= {5'h00, wd_q[2:0]};
         if (wr_prm) prm_q <= {wd_q[7:4], 2'h0, wd_q[1:0]};
         // Trigger bits are pulses, not state
         if (wr_toc) toc_q <= {1'b0, 1'b0, wtoc.oneshot_enable, wtoc.invert_on_b_match,
                               2'h0, wtoc.invert_on_a_match, wtoc.output_enable_bit};
      end
   end

   // Mode register; an overflow in the same cycle as a clear keeps the flag set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tmc_q <= tcco_pkg::TMC_RST;
      end else begin
         if (wr_tmc) tmc_q <= {4'h0, wd_q[3:0]};
         if (wrap) tmc_q.overflow <= 1'b1;
         else if (run == tcco_pkg::RUN_STOP) tmc_q.overflow <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Count clock, pin edges and events
   assign run     = tcco_pkg::tcco_run_t'({tmc_q.run_mode_hi, tmc_q.run_mode_lo});
   assign running = (run != tcco_pkg::RUN_STOP);
   assign a_rise  = running && input_pin_a && !pa_q;
   assign a_fall  = running && !input_pin_a && pa_q;
   assign b_rise  = running && input_pin_b && !pb_q;
   assign b_fall  = running && !input_pin_b && pb_q;
   assign a_edge  = edge_hit({prm_q.edge_sel_a_hi, prm_q.edge_sel_a_lo}, a_rise, a_fall);
   assign b_edge  = edge_hit(prm_q.edge_sel_b, b_rise, b_fall);
   assign a_rev   = rev_hit({prm_q.edge_sel_a_hi, prm_q.edge_sel_a_lo}, a_rise, a_fall);

   // Captures: register a from pin b or reversed pin a, register b from pin a
   assign cap_a_ev = ccc_q.reg_a_capture_sel &&
                     (ccc_q.reg_a_trigger_sel ? a_rev : b_edge);
   assign cap_b_ev = ccc_q.reg_b_capture_sel && a_edge;
   assign rev_irq  = ccc_q.reg_a_capture_sel && ccc_q.reg_a_trigger_sel && b_edge;

   // Count enable; pin-driven count clock relies on long trigger pulses
   always_comb begin
      case (prm_q.clk_sel)
         tcco_pkg::CLK_FULL: tick = running;
         tcco_pkg::CLK_DIV4: tick = running && (div_q == tcco_pkg::DIV_LAST);
         tcco_pkg::CLK_PIN:  tick = a_edge;
         default:            tick = 1'b0;
      endcase
   end

   // Compare hits only while the register works as a compare register
   assign hit_a = tick && !ccc_q.reg_a_capture_sel && (cnt_q == cra_q);
   assign hit_b = tick && !ccc_q.reg_b_capture_sel && (cnt_q == crb_q);
   assign wrap  = tick && (cnt_d == 16'h0000) && (cnt_q == 16'hffff);
   // Toggles run freely, or only inside an armed one-shot window
   assign tog_ok = !toc_q.oneshot_enable || os_act_q;

   // Next count: stop clears, trigger and clear modes restart from zero
   always_comb begin
      cnt_d = cnt_q;
      if (!running) begin
         cnt_d = 16'h0000;
      end else if (wr_toc && wtoc.oneshot_sw_trigger) begin
         cnt_d = 16'h0000;
      end else if (run == tcco_pkg::RUN_EDGE_CLR && a_edge) begin
         cnt_d = 16'h0000;
      end else if (tick) begin
         if (run == tcco_pkg::RUN_MATCH_CLR && hit_a) cnt_d = 16'h0000;
         else cnt_d = cnt_q + 16'h0001;
      end
   end

   // Counter, prescaler and edge history; stop also forgets pin history
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 16'h0000;
         div_q <= 2'h0;
         pa_q  <= 1'b0;
         pb_q  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         div_q <= running ? div_q + 2'h1 : 2'h0;
         pa_q  <= running ? input_pin_a : 1'b0;
         pb_q  <= running ? input_pin_b : 1'b0;
      end
   end

   // Capture registers; a capture beats a software write in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cra_q <= tcco_pkg::CR_RST;
         crb_q <= tcco_pkg::CR_RST;
      end else begin
         if (cap_a_ev) cra_q <= cnt_q;
         else if (wr_cra) cra_q <= {ws_q[1] ? wd_q[15:8] : cra_q[15:8],
                                    ws_q[0] ? wd_q[7:0] : cra_q[7:0]};
         if (cap_b_ev) crb_q <= cnt_q;
         else if (wr_crb) crb_q <= {ws_q[1] ? wd_q[15:8] : crb_q[15:8],
                                    ws_q[0] ? wd_q[7:0] : crb_q[7:0]};
      end
   end

   // One-shot window: armed by trigger, closed by the register a match
   always_ff @(posedge aclk) begin
      if (!aresetn || !running || !toc_q.oneshot_enable) begin
         os_act_q <= 1'b0;
      end else if (run != tcco_pkg::RUN_MATCH_CLR &&
                   ((wr_toc && wtoc.oneshot_sw_trigger) ||
                    (run == tcco_pkg::RUN_EDGE_CLR && a_edge))) begin
         os_act_q <= 1'b1;
      end else if (hit_a) begin
         os_act_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output level and pin; level triggers take priority over match toggles
   always_comb begin
      level_d = level_q;
      if (wr_toc && (wtoc.level_set_trigger ^ wtoc.level_clear_trigger)) begin
         level_d = wtoc.level_set_trigger;
      end else if (tog_ok) begin
         level_d = level_q ^ ((hit_a && toc_q.invert_on_a_match) ^
                              (hit_b && toc_q.invert_on_b_match) ^
                              (tmc_q.invert_on_edge && a_edge));
      end
   end

   // Pin and interrupt pulses, all from flip-flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level_q <= 1'b0;
         pin_q   <= 1'b0;
         irq_a_q <= 1'b0;
         irq_b_q <= 1'b0;
      end else begin
         level_q <= level_d;
         pin_q   <= toc_q.output_enable_bit & level_d;
         irq_a_q <= hit_a || cap_a_ev || rev_irq;
         irq_b_q <= hit_b || cap_b_ev;
      end
   end

   assign timer_out_pin = pin_q;
   assign match_irq_a   = irq_a_q;
   assign match_irq_b   = irq_b_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_pin_low;
      @(posedge aclk) disable iff (!aresetn)
      !toc_q.output_enable_bit |=> !timer_out_pin;
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("pin high while disabled");

   property p_reset_zero;
      @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> (ccc_q == 8'h00) && (toc_q == 8'h00);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("control not cleared");

   property p_cap_b;
      @(posedge aclk) disable iff (!aresetn)
      (ccc_q.reg_b_capture_sel && a_edge) |=> (crb_q == $past(cnt_q));
   endproperty
   a_cap_b: assert property (p_cap_b) else $error("register b missed capture");

   property p_no_both_rev;
      @(posedge aclk) disable iff (!aresetn)
      (ccc_q.reg_a_trigger_sel && prm_q.edge_sel_a_hi && prm_q.edge_sel_a_lo) |-> !cap_a_ev;
   endproperty
   a_no_both_rev: assert property (p_no_both_rev) else $error("both-edge reverse capture");

   property p_rev_irq;
      @(posedge aclk) disable iff (!aresetn)
      (ccc_q.reg_a_capture_sel && ccc_q.reg_a_trigger_sel && b_edge)
         |=> match_irq_a && ($stable(cra_q) || $past(a_rev) || $past(wr_cra));
   endproperty
   a_rev_irq: assert property (p_rev_irq) else $error("pin b edge gave no irq a");

   property p_cmp_a;
      @(posedge aclk) disable iff (!aresetn)
      !ccc_q.reg_a_capture_sel |=> $stable(cra_q) || $past(wr_cra);
   endproperty
   a_cmp_a: assert property (p_cmp_a) else $error("compare register captured");

   property p_os_clear;
      @(posedge aclk) disable iff (!aresetn)
      (wr_toc && wtoc.oneshot_sw_trigger && running) |=> (cnt_q == 16'h0000);
   endproperty
   a_os_clear: assert property (p_os_clear) else $error("trigger did not clear count");

   property p_stop;
      @(posedge aclk) disable iff (!aresetn)
      (run == tcco_pkg::RUN_STOP) [*2] |-> (cnt_q == 16'h0000) && !match_irq_b;
   endproperty
   a_stop: assert property (p_stop) else $error("stopped counter not clear");

   property p_lvl_set;
      @(posedge aclk) disable iff (!aresetn)
      (wr_toc && wtoc.level_set_trigger && !wtoc.level_clear_trigger && toc_q.output_enable_bit)
         |=> level_q ##1 timer_out_pin || !toc_q.output_enable_bit || $changed(level_q);
   endproperty
   a_lvl_set: assert property (p_lvl_set) else $error("level set not seen");

   property p_irq_b;
      @(posedge aclk) disable iff (!aresetn)
      hit_b |=> match_irq_b;
   endproperty
   a_irq_b: assert property (p_irq_b) else $error("match b gave no irq");
endmodule

// File: tcco_pin_model.sv
/*
 * Pin-side partner: drives the two timer input pins.
 * Assumes the bench calls pulse from its own sequence, one at a time.
 */
`timescale 1ns/1ps
module tcco_pin_model (
   // Clock
   input  wire logic aclk,
   // Pins driven towards the timer
   output      logic pin_a,
   output      logic pin_b
);
   ////////////////////////////////////////////////////////////
   // Lines are pulled low when idle, so low is the rest level
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
   end

   // Pulse held n cycles, well past the count clock
   task automatic pulse(input logic sel, input int n);
      @(posedge aclk);
      if (sel)
         pin_b <= 1'b1;
      else
         pin_a <= 1'b1;
      repeat (n) @(posedge aclk);
      pin_a <= 1'b0;
      pin_b <= 1'b0;
   endtask
endmodule

// File: timer_capture_compare_output_ctrl_test.sv
/*
 * Self-checking bench for the timer capture/compare and output block.
 * Assumes tcco_pkg, tcco_top and tcco_pin_model are compiled first.
 */
`timescale 1ns/1ps
module timer_capture_compare_output_ctrl_test;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [tcco_pkg::ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, v;
   logic [3:0]  wstrb = 4'hf;
   logic [1:0]  bresp, rresp, r;
   logic        awready, wready, bvalid, arready, rvalid, input_pin_a, input_pin_b;
   logic        timer_out_pin, match_irq_a, match_irq_b;
   int          miscompares, total_checks, na, nb, cyc;
   // Level loop writes, pin levels after each, irq counts per edge code
   localparam logic [7:0] LV [4] = '{8'h17, 8'h1b, 8'h13, 8'h12};
   localparam logic [3:0] PE     = 4'b0110;
   localparam int         NE [4] = '{1, 1, 0, 2};

   tcco_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .input_pin_a, .input_pin_b, .timer_out_pin, .match_irq_a,
      .match_irq_b);
   tcco_pin_model pins (.aclk, .pin_a(input_pin_a), .pin_b(input_pin_b));

   // Clock
   always #5 aclk = ~aclk;

   // Event counters and hang limit; a run takes well under 2000 cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (match_irq_a) na++;
      if (match_irq_b) nb++;
      if (cyc == 5000) begin
         miscompares++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Write: address and data offered together, each dropped once taken;
   // bready stays up so back-to-back calls never drive it twice in one step
   task automatic wr(input logic [15:0] i, input logic [31:0] d);
      awaddr  <= {i, 2'h0};
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
   endtask

   // Read: data and response taken at the edge where rvalid is seen
   task automatic rd(input logic [15:0] i);
      araddr  <= {i, 2'h0};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      v = rdata;
      r = rresp;
   endtask

   // Reconfigure only while stopped, then restart in run mode m
   task automatic cfg(input logic [7:0] c, input logic [7:0] p, input logic [15:0] a,
                      input logic [7:0] m = 8'h4);
      wr(tcco_pkg::IDX_TMC, 32'h0);
      wr(tcco_pkg::IDX_CCC, {24'h0, c});
      wr(tcco_pkg::IDX_PRM, {24'h0, p});
      wr(tcco_pkg::IDX_CRA, {16'h0, a});
      wr(tcco_pkg::IDX_TMC, {24'h0, m});
      na = 0;
      nb = 0;
   endtask

   ////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(tcco_pkg::IDX_CCC);
      chk(v, {24'h0, tcco_pkg::CCC_RST});
      rd(tcco_pkg::IDX_TOC);
      chk(v, {24'h0, tcco_pkg::TOC_RST});
      rd(16'h0000);
      chk({30'h0, r}, {30'h0, tcco_pkg::RESP_SLVERR});
      chk(v, 32'h0);
      wr(16'h0000, 32'hff);
      chk({30'h0, r}, {30'h0, tcco_pkg::RESP_SLVERR});
      chk({31'h0, timer_out_pin}, 32'h0);
   endtask

   task automatic t_match;
      wr(tcco_pkg::IDX_CRB, 32'h5);
      chk({30'h0, r}, {30'h0, tcco_pkg::RESP_OKAY});
      wr(tcco_pkg::IDX_CRA, 32'h8);
      wr(tcco_pkg::IDX_TOC, 32'h12); // Inverts first
      wr(tcco_pkg::IDX_TOC, 32'h13); // Enable alone
      wr(tcco_pkg::IDX_TOC, 32'h1b); // Start level high
      na = 0;
      nb = 0;
      wr(tcco_pkg::IDX_TMC, 32'h4);
      repeat (20) @(posedge aclk);
      chk(32'(nb), 32'h1);
      chk(32'(na), 32'h1);
      chk({31'h0, timer_out_pin}, 32'h1); // Two toggles
      wr(tcco_pkg::IDX_TMC, 32'h0);
      for (int k = 0; k < 4; k++) begin
         wr(tcco_pkg::IDX_TOC, {24'h0, LV[k]});
         rd(tcco_pkg::IDX_TOC);
         chk(v, {24'h0, LV[k] & 8'h33});
         chk({31'h0, timer_out_pin}, {31'h0, PE[k]});
      end
   endtask

   // Pin a pulse of four cycles starts two counts in: rise at 2, fall at 6
   task automatic t_capb;
      for (int c = 0; c < 4; c++) begin
         cfg(8'h4, {2'h0, c[1:0], 4'h0}, 16'hffff);
         pins.pulse(1'b0, 4);
         repeat (3) @(posedge aclk);
         chk(32'(nb), 32'(NE[c]));
      end
      rd(tcco_pkg::IDX_CRB);
      chk(v, 32'h6); // Both edges, last capture on the fall
   endtask

   task automatic t_rev;
      cfg(8'h1, 8'h40, 16'h1234);
      pins.pulse(1'b1, 4);
      repeat (3) @(posedge aclk);
      rd(tcco_pkg::IDX_CRA);
      chk(v, 32'h2); // Captured at the pin b rise
      chk(32'(na), 32'h1);
      cfg(8'h3, 8'h70, 16'h1234);
      pins.pulse(1'b1, 4);
      repeat (3) @(posedge aclk);
      chk(32'(na), 32'h1);
      pins.pulse(1'b0, 4);
      repeat (3) @(posedge aclk);
      rd(tcco_pkg::IDX_CRA);
      chk(v, 32'h1234);
      chk(32'(na), 32'h1); // No capture irq from both edges
      cfg(8'h3, 8'h50, 16'h1234);
      pins.pulse(1'b0, 4);
      repeat (3) @(posedge aclk);
      rd(tcco_pkg::IDX_CRA);
      chk(v, 32'h6); // Rising selected, captured on the fall
      chk(32'(na), 32'h1);
   endtask

   task automatic t_oneshot;
      wr(tcco_pkg::IDX_TMC, 32'h0);
      wr(tcco_pkg::IDX_TOC, 32'h32); // Mode and inverts first
      wr(tcco_pkg::IDX_TOC, 32'h33);
      wr(tcco_pkg::IDX_TOC, 32'h3b); // Level high once enabled
      wr(tcco_pkg::IDX_TMC, 32'h4);
      repeat (30) @(posedge aclk);
      chk({31'h0, timer_out_pin}, 32'h1); // No toggle before trigger
      wr(tcco_pkg::IDX_TOC, 32'h73); // Only the trigger changes
      rd(tcco_pkg::IDX_CNT);
      chk(v, 32'h1);
      rd(tcco_pkg::IDX_TOC);
      chk(v, 32'h33);
      repeat (10) @(posedge aclk);
      chk({31'h0, timer_out_pin}, 32'h0); // Match b toggles once
   endtask

   // Match-clear interval of four counts; one-shot stays closed there
   task automatic t_interval;
      cfg(8'h0, 8'h0, 16'h3, 8'hc); // Register a compares
      wr(tcco_pkg::IDX_TOC, 32'h73);
      repeat (38) @(posedge aclk);
      chk(32'(na), 32'h9);
      chk({31'h0, timer_out_pin}, 32'h0);
   endtask

   // Main sequence
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      $display("reset test done");
      t_match();
      $display("match and level test done");
      t_capb();
      $display("capture b test done");
      t_rev();
      $display("capture a test done");
      t_oneshot();
      $display("one-shot test done");
      t_interval();
      $display("interval test done");
      end_sim();
   end
endmodule
